// ---- core/tmr16_consts.svh ----
`ifndef TMR16_CONSTS_SVH
`define TMR16_CONSTS_SVH

// Register byte offsets
`define TMR16_OFS_CTRL_A 8'h80
`define TMR16_OFS_CTRL_B 8'h81
`define TMR16_OFS_CNT_LO 8'h84
`define TMR16_OFS_CNT_HI 8'h85
`define TMR16_OFS_CAP_LO 8'h86
`define TMR16_OFS_CAP_HI 8'h87
`define TMR16_OFS_CMPA_LO 8'h88
`define TMR16_OFS_CMPA_HI 8'h89
`define TMR16_OFS_CMPB_LO 8'h8A
`define TMR16_OFS_CMPB_HI 8'h8B
`define TMR16_OFS_FLAGS 8'h8C

// Reset values and writable masks
`define TMR16_CTRL_A_RST 8'h00
`define TMR16_CTRL_B_RST 8'h00
`define TMR16_CTRL_A_MASK 8'hF3
`define TMR16_CTRL_B_MASK 8'hDF
`define TMR16_FLAG_MASK 4'hF
`define TMR16_RDATA_IDLE 8'h00

// Flag bit positions
`define TMR16_FLAG_OVF 0
`define TMR16_FLAG_MATCH_A 1
`define TMR16_FLAG_MATCH_B 2
`define TMR16_FLAG_CAP 3

// Waveform mode numbers
`define TMR16_MODE_NORMAL 4'h0
`define TMR16_MODE_PC8 4'h1
`define TMR16_MODE_PC9 4'h2
`define TMR16_MODE_PC10 4'h3
`define TMR16_MODE_CTC_CMP 4'h4
`define TMR16_MODE_FAST8 4'h5
`define TMR16_MODE_FAST9 4'h6
`define TMR16_MODE_FAST10 4'h7
`define TMR16_MODE_PFC_CAP 4'h8
`define TMR16_MODE_PFC_CMP 4'h9
`define TMR16_MODE_PC_CAP 4'hA
`define TMR16_MODE_PC_CMP 4'hB
`define TMR16_MODE_CTC_CAP 4'hC
`define TMR16_MODE_FAST_CAP 4'hE
`define TMR16_MODE_FAST_CMP 4'hF

// Counter extremes
`define TMR16_BOTTOM 16'h0000
`define TMR16_MAX 16'hFFFF
`define TMR16_TOP_8 16'h00FF
`define TMR16_TOP_9 16'h01FF
`define TMR16_TOP_10 16'h03FF

// Output action codes
`define TMR16_COM_OFF 2'h0
`define TMR16_COM_TOGGLE 2'h1
`define TMR16_COM_CLEAR 2'h2
`define TMR16_COM_SET 2'h3

// Tick source select codes and prescaler masks
`define TMR16_SEL_STOP 3'h0
`define TMR16_SEL_DIV1 3'h1
`define TMR16_SEL_DIV8 3'h2
`define TMR16_SEL_DIV64 3'h3
`define TMR16_SEL_DIV256 3'h4
`define TMR16_SEL_DIV1024 3'h5
`define TMR16_SEL_EXT_FALL 3'h6
`define TMR16_SEL_EXT_RISE 3'h7
`define TMR16_PRE_MASK8 10'h007
`define TMR16_PRE_MASK64 10'h03F
`define TMR16_PRE_MASK256 10'h0FF
`define TMR16_PRE_MASK1024 10'h3FF

`endif

// ---- core/tmr16_pkg.sv ----
package tmr16_pkg;

  typedef enum logic [2:0] {
    MC_NORMAL,
    MC_CTC,
    MC_FAST,
    MC_PHASE,
    MC_PFC
  } tmr16_class_type;

  typedef struct packed {
    logic [1:0] com_a;
    logic [1:0] com_b;
    logic [1:0] rsvd;
    logic [1:0] wgm_low;
  } tmr16_ctrl_a_type;

  typedef struct packed {
    logic noise_cancel;
    logic edge_rise;
    logic rsvd;
    logic [1:0] wgm_high;
    logic [2:0] tick_sel;
  } tmr16_ctrl_b_type;

endpackage

// ---- core/tmr16_tick_gen.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "tmr16_consts.svh"

module tmr16_tick_gen (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [2:0] sel_i,
  input wire logic ext_pin_i,
  output logic tick_o
);
  logic [9:0] pre_r;
  logic s1_r, s2_r, s3_r, lvl_r, tick_r;
  wire ext_mode = sel_i[2] & sel_i[1];
  // Only the settled pair is compared; the first stage may be metastable
  wire settled = (s2_r == s3_r);
  wire ext_edge = settled && (s3_r != lvl_r) && (s3_r == sel_i[0]);
  wire [9:0] mask = (sel_i == `TMR16_SEL_DIV8) ? `TMR16_PRE_MASK8 :
                    (sel_i == `TMR16_SEL_DIV64) ? `TMR16_PRE_MASK64 :
                    (sel_i == `TMR16_SEL_DIV256) ? `TMR16_PRE_MASK256 :
                    `TMR16_PRE_MASK1024;
  wire pre_hit = ((pre_r & mask) == mask);
  wire tick_nxt = (sel_i == `TMR16_SEL_STOP) ? 1'b0 :
                  (sel_i == `TMR16_SEL_DIV1) ? 1'b1 :
                  ext_mode ? ext_edge : pre_hit;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pre_r <= 10'h000;
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      lvl_r <= 1'b0;
      tick_r <= 1'b0;
    end else begin
      pre_r <= pre_r + 10'h001;
      s1_r <= ext_pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (settled) begin
        lvl_r <= s3_r;
      end
      tick_r <= tick_nxt;
    end
  end

  assign tick_o = tick_r;

  stop_no_tick_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (sel_i == `TMR16_SEL_STOP) |=> !tick_o)
    else $error("tick seen while stopped");

endmodule
`default_nettype wire

// ---- core/tmr16_wave_ctrl.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "tmr16_consts.svh"
// Overview of operation
// - All logic on I/O clock, tick enables.
// - Phase-frequency modes load compares at BOTTOM.
// - Nonzero action field takes over pin, except toggle where toggle is not allowed.
// - Driver enabled only when direction is output.
// - Non-PWM: off, toggle, clear, set on match.
// - Fast toggle: A only in 14/15.
// - Fast: 10 non-inverting, 11 inverting.
// - Fast compare at TOP: bottom action only.
// - Dual-slope toggle: A only in 9/11.
// - Dual-slope: level depends on count direction.
// - Mode from control A low, B high.
// - Mode 0: TOP MAX, immediate, overflow MAX.
// - CTC TOP compare A or capture, immediate.
// - Phase correct TOPs, load TOP, overflow BOTTOM.
// - Phase-frequency TOP sources, load and overflow BOTTOM.
// - Fast TOPs, load BOTTOM, overflow at TOP.
// - Tick select: stop, dividers, external edges.
// - Capture disabled while capture sets TOP.

module tmr16_wave_ctrl (
  input wire logic CORE_CLK_I,
  input wire logic RSTN_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [7:0] REG_RDATA_O,
  input wire logic EXT_TICK_PIN_I,
  input wire logic CAPTURE_INPUT_PIN_I,
  input wire logic CHAN_A_DIR_I,
  input wire logic CHAN_B_DIR_I,
  output logic CHAN_A_WAVE_OUT_O,
  output logic CHAN_B_WAVE_OUT_O,
  output logic CHAN_A_OVERRIDE_O,
  output logic CHAN_B_OVERRIDE_O,
  output logic CHAN_A_OE_N_O,
  output logic CHAN_B_OE_N_O,
  output logic OVERFLOW_FLAG_O,
  output logic [1:0] COMPARE_MATCH_FLAG_O
);
  import tmr16_pkg::*;

  function automatic tmr16_class_type class_of(input logic [3:0] m);
    case (m)
      `TMR16_MODE_NORMAL: class_of = MC_NORMAL;
      `TMR16_MODE_CTC_CMP, `TMR16_MODE_CTC_CAP: class_of = MC_CTC;
      `TMR16_MODE_FAST8, `TMR16_MODE_FAST9, `TMR16_MODE_FAST10,
      `TMR16_MODE_FAST_CAP, `TMR16_MODE_FAST_CMP: class_of = MC_FAST;
      `TMR16_MODE_PC8, `TMR16_MODE_PC9, `TMR16_MODE_PC10,
      `TMR16_MODE_PC_CAP, `TMR16_MODE_PC_CMP: class_of = MC_PHASE;
      `TMR16_MODE_PFC_CAP, `TMR16_MODE_PFC_CMP: class_of = MC_PFC;
      default: class_of = MC_NORMAL;
    endcase
  endfunction

  function automatic logic cap_is_top(input logic [3:0] m);
    cap_is_top = (m == `TMR16_MODE_PFC_CAP) || (m == `TMR16_MODE_PC_CAP) ||
                 (m == `TMR16_MODE_CTC_CAP) || (m == `TMR16_MODE_FAST_CAP);
  endfunction

  function automatic logic cmp_is_top(input logic [3:0] m);
    cmp_is_top = (m == `TMR16_MODE_CTC_CMP) || (m == `TMR16_MODE_PFC_CMP) ||
                 (m == `TMR16_MODE_PC_CMP) || (m == `TMR16_MODE_FAST_CMP);
  endfunction

  tmr16_ctrl_a_type ctrl_a_r;
  tmr16_ctrl_b_type ctrl_b_r;
  logic [15:0] cnt_r, cnt_nxt, cap_r;
  logic up_r, up_nxt;
  logic [3:0] flags_r;
  logic [7:0] rdata_r;
  logic cs1_r, cs2_r, cs3_r, cap_lvl_r;
  wire tick;
  wire [1:0] match_evt;
  wire [15:0] cmp_a_act;
  wire [15:0] cmp_b_act;

  tmr16_tick_gen u_tick (
    .clk_i(CORE_CLK_I),
    .rstn_i(RSTN_I),
    .sel_i(ctrl_b_r.tick_sel),
    .ext_pin_i(EXT_TICK_PIN_I),
    .tick_o(tick)
  );

  wire [3:0] mode = {ctrl_b_r.wgm_high, ctrl_a_r.wgm_low};
  wire tmr16_class_type mclass = class_of(mode);
  wire dual = (mclass == MC_PHASE) || (mclass == MC_PFC);
  wire immediate = (mclass == MC_NORMAL) || (mclass == MC_CTC);
  wire [15:0] top = cap_is_top(mode) ? cap_r :
                    cmp_is_top(mode) ? cmp_a_act :
                    (mode == `TMR16_MODE_PC8 || mode == `TMR16_MODE_FAST8) ? `TMR16_TOP_8 :
                    (mode == `TMR16_MODE_PC9 || mode == `TMR16_MODE_FAST9) ? `TMR16_TOP_9 :
                    (mode == `TMR16_MODE_PC10 || mode == `TMR16_MODE_FAST10) ? `TMR16_TOP_10 :
                    `TMR16_MAX;
  wire at_top = (cnt_r == top);
  wire at_bot = (cnt_r == `TMR16_BOTTOM);
  wire at_max = (cnt_r == `TMR16_MAX);

  // Register strobes
  wire wr_ctrl_a = REG_WR_I && (REG_ADDR_I == `TMR16_OFS_CTRL_A);
  wire wr_ctrl_b = REG_WR_I && (REG_ADDR_I == `TMR16_OFS_CTRL_B);
  wire wr_cnt_lo = REG_WR_I && (REG_ADDR_I == `TMR16_OFS_CNT_LO);
  wire wr_cnt_hi = REG_WR_I && (REG_ADDR_I == `TMR16_OFS_CNT_HI);
  wire wr_cap_lo = REG_WR_I && (REG_ADDR_I == `TMR16_OFS_CAP_LO);
  wire wr_cap_hi = REG_WR_I && (REG_ADDR_I == `TMR16_OFS_CAP_HI);
  wire wr_flags = REG_WR_I && (REG_ADDR_I == `TMR16_OFS_FLAGS);

  // Counter sequence; a software write takes priority over the tick
  always_comb begin
    cnt_nxt = cnt_r;
    up_nxt = up_r;
    if (wr_cnt_lo) begin
      cnt_nxt = {cnt_r[15:8], REG_WDATA_I};
    end else if (wr_cnt_hi) begin
      cnt_nxt = {REG_WDATA_I, cnt_r[7:0]};
    end else if (tick) begin
      if (dual) begin
        if (up_r && (cnt_r >= top)) begin
          up_nxt = 1'b0;
          cnt_nxt = cnt_r - 16'h0001;
        end else if (!up_r && at_bot) begin
          up_nxt = 1'b1;
          cnt_nxt = cnt_r + 16'h0001;
        end else if (up_r) begin
          cnt_nxt = cnt_r + 16'h0001;
        end else begin
          cnt_nxt = cnt_r - 16'h0001;
        end
      end else if (at_top) begin
        cnt_nxt = `TMR16_BOTTOM;
      end else begin
        cnt_nxt = cnt_r + 16'h0001;
      end
    end
  end

  // Overflow point and buffer load point per mode class
  wire ovf_evt = tick && (immediate ? at_max : (mclass == MC_FAST) ? at_top : at_bot);
  wire load_evt = tick && !immediate && ((mclass == MC_PHASE) ? at_top : at_bot);

  // Capture pin: only the settled second and third stages are looked at
  wire cap_settled = (cs2_r == cs3_r);
  wire cap_edge = cap_settled && (cs3_r != cap_lvl_r) && (cs3_r == ctrl_b_r.edge_rise);
  wire cap_evt = cap_edge && !cap_is_top(mode);

  wire [3:0] flag_set = {cap_evt, match_evt, ovf_evt};
  wire [3:0] flag_clr = wr_flags ? (REG_WDATA_I[3:0] & `TMR16_FLAG_MASK) : 4'h0;
  // Set wins over a clear in the same cycle
  wire [3:0] flags_nxt = (flags_r & ~flag_clr) | flag_set;

  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ctrl_a_r <= `TMR16_CTRL_A_RST;
      ctrl_b_r <= `TMR16_CTRL_B_RST;
      cnt_r <= `TMR16_BOTTOM;
      up_r <= 1'b1;
      flags_r <= 4'h0;
    end else begin
      if (wr_ctrl_a) begin
        ctrl_a_r <= REG_WDATA_I & `TMR16_CTRL_A_MASK;
      end
      if (wr_ctrl_b) begin
        ctrl_b_r <= REG_WDATA_I & `TMR16_CTRL_B_MASK;
      end
      cnt_r <= cnt_nxt;
      up_r <= up_nxt;
      flags_r <= flags_nxt;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      cap_r <= `TMR16_BOTTOM;
      cs1_r <= 1'b0;
      cs2_r <= 1'b0;
      cs3_r <= 1'b0;
      cap_lvl_r <= 1'b0;
    end else begin
      cs1_r <= CAPTURE_INPUT_PIN_I;
      cs2_r <= cs1_r;
      cs3_r <= cs2_r;
      if (cap_settled) begin
        cap_lvl_r <= cs3_r;
      end
      if (cap_evt) begin
        cap_r <= cnt_r;
      end else if (wr_cap_lo) begin
        cap_r <= {cap_r[15:8], REG_WDATA_I};
      end else if (wr_cap_hi) begin
        cap_r <= {REG_WDATA_I, cap_r[7:0]};
      end
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      logic [15:0] buf_r, act_r;
      logic wave_r, ovr_r, oen_r, wave_nxt;
      wire [7:0] ofs_lo = (ch == 0) ? `TMR16_OFS_CMPA_LO : `TMR16_OFS_CMPB_LO;
      wire [7:0] ofs_hi = (ch == 0) ? `TMR16_OFS_CMPA_HI : `TMR16_OFS_CMPB_HI;
      wire wr_lo = REG_WR_I && (REG_ADDR_I == ofs_lo);
      wire wr_hi = REG_WR_I && (REG_ADDR_I == ofs_hi);
      wire [1:0] com = (ch == 0) ? ctrl_a_r.com_a : ctrl_a_r.com_b;
      wire [15:0] buf_nxt = wr_lo ? {buf_r[15:8], REG_WDATA_I} :
                            wr_hi ? {REG_WDATA_I, buf_r[7:0]} : buf_r;
      wire toggle_ok = (mclass == MC_FAST) ? ((ch == 0) && mode[3] && mode[2] && mode[1]) :
                       dual ? ((ch == 0) && mode[3] && mode[0] && !mode[2]) :
                       1'b1;
      wire connected = (com != `TMR16_COM_OFF) &&
                       !((com == `TMR16_COM_TOGGLE) && !toggle_ok);
      wire match = match_evt[ch];
      wire match_at_top = (act_r == top) && com[1];

      assign match_evt[ch] = tick && (cnt_r == act_r);

      always_comb begin
        wave_nxt = wave_r;
        if (connected) begin
          if (com == `TMR16_COM_TOGGLE) begin
            if (match) begin
              wave_nxt = !wave_r;
            end
          end else if (immediate) begin
            if (match) begin
              wave_nxt = com[0];
            end
          end else if (mclass == MC_FAST) begin
            if (match && !match_at_top) begin
              wave_nxt = com[0];
            end else if (tick && at_bot) begin
              wave_nxt = !com[0];
            end
          end else if (match) begin
            wave_nxt = up_r ? com[0] : !com[0];
          end
        end
      end

      always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
          buf_r <= `TMR16_BOTTOM;
          act_r <= `TMR16_BOTTOM;
          wave_r <= 1'b0;
          ovr_r <= 1'b0;
          oen_r <= 1'b1;
        end else begin
          buf_r <= buf_nxt;
          if (immediate) begin
            act_r <= buf_nxt;
          end else if (load_evt) begin
            act_r <= buf_r;
          end
          wave_r <= wave_nxt;
          ovr_r <= connected;
          oen_r <= !(connected && ((ch == 0) ? CHAN_A_DIR_I : CHAN_B_DIR_I));
        end
      end
    end
  endgenerate

  assign cmp_a_act = g_ch[0].act_r;
  assign cmp_b_act = g_ch[1].act_r;

  // Read mux; unmapped addresses read zero
  wire [7:0] rd_mux =
    (REG_ADDR_I == `TMR16_OFS_CTRL_A) ? ctrl_a_r :
    (REG_ADDR_I == `TMR16_OFS_CTRL_B) ? ctrl_b_r :
    (REG_ADDR_I == `TMR16_OFS_CNT_LO) ? cnt_r[7:0] :
    (REG_ADDR_I == `TMR16_OFS_CNT_HI) ? cnt_r[15:8] :
    (REG_ADDR_I == `TMR16_OFS_CAP_LO) ? cap_r[7:0] :
    (REG_ADDR_I == `TMR16_OFS_CAP_HI) ? cap_r[15:8] :
    (REG_ADDR_I == `TMR16_OFS_CMPA_LO) ? g_ch[0].buf_r[7:0] :
    (REG_ADDR_I == `TMR16_OFS_CMPA_HI) ? g_ch[0].buf_r[15:8] :
    (REG_ADDR_I == `TMR16_OFS_CMPB_LO) ? g_ch[1].buf_r[7:0] :
    (REG_ADDR_I == `TMR16_OFS_CMPB_HI) ? g_ch[1].buf_r[15:8] :
    (REG_ADDR_I == `TMR16_OFS_FLAGS) ? {4'h0, flags_r} :
    `TMR16_RDATA_IDLE;

  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rdata_r <= `TMR16_RDATA_IDLE;
    end else begin
      rdata_r <= REG_RD_I ? rd_mux : `TMR16_RDATA_IDLE;
    end
  end

  assign REG_RDATA_O = rdata_r;
  assign CHAN_A_WAVE_OUT_O = g_ch[0].wave_r;
  assign CHAN_B_WAVE_OUT_O = g_ch[1].wave_r;
  assign CHAN_A_OVERRIDE_O = g_ch[0].ovr_r;
  assign CHAN_B_OVERRIDE_O = g_ch[1].ovr_r;
  assign CHAN_A_OE_N_O = g_ch[0].oen_r;
  assign CHAN_B_OE_N_O = g_ch[1].oen_r;
  assign OVERFLOW_FLAG_O = flags_r[`TMR16_FLAG_OVF];
  assign COMPARE_MATCH_FLAG_O = {flags_r[`TMR16_FLAG_MATCH_B], flags_r[`TMR16_FLAG_MATCH_A]};

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RSTN_I);

  ovf_at_max_a: assert property (
    (mode == `TMR16_MODE_NORMAL) && tick && at_max |=> OVERFLOW_FLAG_O && (cnt_r == 16'h0000))
    else $error("normal mode overflow missing at MAX");

  fast8_wrap_a: assert property (
    (mode == `TMR16_MODE_FAST8) && tick && (cnt_r == 16'h00FF) && !REG_WR_I
    |=> (cnt_r == 16'h0000) && OVERFLOW_FLAG_O)
    else $error("fast 8-bit wrap or overflow wrong");

  pfc_load_a: assert property (
    (mclass == MC_PFC) && tick && at_bot |=> (cmp_a_act == $past(g_ch[0].buf_r)))
    else $error("phase-frequency buffer not loaded at BOTTOM");

  pc_hold_a: assert property (
    (mclass == MC_PHASE) && !(tick && at_top) |=> (cmp_b_act == $past(cmp_b_act)))
    else $error("phase correct compare changed away from TOP");

  oe_dir_a: assert property (
    !CHAN_A_DIR_I |=> CHAN_A_OE_N_O)
    else $error("driver enabled while pin is input");

  override_off_a: assert property (
    (ctrl_a_r.com_b == `TMR16_COM_OFF) |=> !CHAN_B_OVERRIDE_O ##0 CHAN_B_OE_N_O)
    else $error("disconnected channel still overrides pin");

  toggle_match_a: assert property (
    immediate && (ctrl_a_r.com_a == `TMR16_COM_TOGGLE) && match_evt[0]
    |=> CHAN_A_WAVE_OUT_O != $past(CHAN_A_WAVE_OUT_O))
    else $error("toggle on match missing");

  fast_b_disc_a: assert property (
    (mclass == MC_FAST) && (ctrl_a_r.com_b == `TMR16_COM_TOGGLE) |=> !CHAN_B_OVERRIDE_O)
    else $error("channel B connected with fast toggle");

  dual_up_clr_a: assert property (
    dual && (ctrl_a_r.com_a == `TMR16_COM_CLEAR) && match_evt[0] && up_r
    |=> !CHAN_A_WAVE_OUT_O)
    else $error("dual slope up-count match did not clear");

  capture_off_a: assert property (
    cap_is_top(mode) && !wr_cap_lo && !wr_cap_hi |=> $stable(cap_r))
    else $error("capture taken while capture sets TOP");

  flag_set_wins_a: assert property (
    match_evt[1] && wr_flags |=> COMPARE_MATCH_FLAG_O[1])
    else $error("match flag lost to a clear");

endmodule
`default_nettype wire

// ---- test/tmr16_wave_ctrl_test.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "tmr16_consts.svh"

module tmr16_wave_ctrl_test;
  import tmr16_pkg::*;

  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic ext_pin = 1'b0;
  logic cap_pin = 1'b0;
  logic dir_a = 1'b1;
  logic dir_b = 1'b1;
  logic [7:0] rdata;
  logic wave_a, wave_b, ovr_a, ovr_b, oe_n_a, oe_n_b, ovf;
  logic [1:0] match;
  int bad_count = 0;
  int comparisons = 0;

  tmr16_wave_ctrl tmr16_wave_ctrl_i (
    .CORE_CLK_I(clk), .RSTN_I(rstn), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
    .REG_WR_I(wr_s), .REG_RD_I(rd_s), .REG_RDATA_O(rdata), .EXT_TICK_PIN_I(ext_pin),
    .CAPTURE_INPUT_PIN_I(cap_pin), .CHAN_A_DIR_I(dir_a), .CHAN_B_DIR_I(dir_b),
    .CHAN_A_WAVE_OUT_O(wave_a), .CHAN_B_WAVE_OUT_O(wave_b), .CHAN_A_OVERRIDE_O(ovr_a),
    .CHAN_B_OVERRIDE_O(ovr_b), .CHAN_A_OE_N_O(oe_n_a), .CHAN_B_OE_N_O(oe_n_b),
    .OVERFLOW_FLAG_O(ovf), .COMPARE_MATCH_FLAG_O(match)
  );

  always #5 clk = ~clk;

  task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask

  // Read data is sampled once, in the only cycle it stands
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    d = rdata;
  endtask

  task rd16(input logic [7:0] a, output logic [15:0] d);
    logic [7:0] lo, hi;
    rd(a, lo);
    rd(a + 8'h01, hi);
    d = {hi, lo};
  endtask

  // Stops the tick and parks in mode 0, so the compare lands at once and the
  // upper mode bits never pair with stale lower bits into the reserved mode
  task cfg(input logic [3:0] m, input logic [1:0] ca, input logic [1:0] cb,
           input logic [15:0] cmp, input logic [15:0] cnt, input logic [2:0] sel);
    wr(`TMR16_OFS_CTRL_B, 8'h00);
    wr(`TMR16_OFS_CTRL_A, 8'h00);
    wr(`TMR16_OFS_CMPA_LO, cmp[7:0]);
    wr(`TMR16_OFS_CMPA_HI, cmp[15:8]);
    wr(`TMR16_OFS_CNT_LO, cnt[7:0]);
    wr(`TMR16_OFS_CNT_HI, cnt[15:8]);
    wr(`TMR16_OFS_FLAGS, 8'h0F);
    wr(`TMR16_OFS_CTRL_A, {ca, cb, 2'b00, m[1:0]});
    wr(`TMR16_OFS_CTRL_B, {3'b000, m[3:2], sel});
  endtask

  // Bounded wait for a flag: 0 overflow, 1 match A
  task wait_flag(input int which, input int lim);
    int n;
    logic hit;
    hit = 1'b0;
    for (n = 0; n < lim && !hit; n++) begin
      @(posedge clk);
      #1;
      hit = (which == 0) ? (ovf === 1'b1) : (match[0] === 1'b1);
    end
    comparisons++;
    if (!hit) begin
      bad_count++;
      $display("[FAIL] %0t flag %0d never set", $time, which);
    end
  endtask

  task pulse(input logic on_cap, input int n);
    repeat (n) begin
      @(posedge clk);
      if (on_cap) cap_pin <= 1'b1; else ext_pin <= 1'b1;
      repeat (5) @(posedge clk);
      if (on_cap) cap_pin <= 1'b0; else ext_pin <= 1'b0;
      repeat (5) @(posedge clk);
    end
  endtask

  task t_regs;
    logic [7:0] d;
    rd(`TMR16_OFS_CTRL_A, d); chk(d, 8'h00, "ctrl A reset");
    rd(`TMR16_OFS_CTRL_B, d); chk(d, 8'h00, "ctrl B reset");
    wr(`TMR16_OFS_CTRL_A, 8'hFF);
    rd(`TMR16_OFS_CTRL_A, d); chk(d, 8'hF3, "ctrl A reserved bits");
    @(posedge clk); #1; chk(rdata, 8'h00, "read data after its cycle");
    wr(`TMR16_OFS_CTRL_B, 8'hDF);
    rd(`TMR16_OFS_CTRL_B, d); chk(d, 8'hDF, "ctrl B readback");
    wr(8'h90, 8'h00);
    rd(8'h90, d); chk(d, 8'h00, "unmapped read");
    rd(`TMR16_OFS_CTRL_A, d); chk(d, 8'hF3, "unmapped write ignored");
    wr(`TMR16_OFS_CTRL_B, 8'h00);
    wr(`TMR16_OFS_CTRL_A, 8'h00);
  endtask

  // Pin ownership for each class of mode; the tick stays stopped
  task t_override;
    logic [3:0] md [9] = '{4'd0, 4'd5, 4'd15, 4'd14, 4'd1, 4'd11, 4'd9, 4'd4, 4'd12};
    logic [1:0] ea [9] = '{1, 0, 1, 1, 0, 1, 1, 1, 0};
    logic [1:0] eb [9] = '{1, 0, 0, 0, 0, 0, 0, 1, 0};
    int i;
    for (i = 0; i < 9; i++) begin
      cfg(md[i], (i < 7) ? 2'b01 : 2'b10, (i < 7) ? 2'b01 : 2'b11, 16'h0000,
          16'h0000, `TMR16_SEL_STOP);
      if (i == 8) wr(`TMR16_OFS_CTRL_A, 8'h00);
      repeat (2) @(posedge clk);
      #1;
      chk(ovr_a, ea[i][0], "override A by mode");
      chk(ovr_b, eb[i][0], "override B by mode");
    end
  endtask

  task t_normal;
    int c;
    cfg(`TMR16_MODE_NORMAL, `TMR16_COM_TOGGLE, `TMR16_COM_OFF, 16'h0002, 16'h0000,
        `TMR16_SEL_DIV1);
    wait_flag(1, 20);
    chk(wave_a, 1'b1, "toggle on match");
    chk(ovr_a, 1'b1, "A owns pin");
    chk(oe_n_a, 1'b0, "A driver on");
    chk(oe_n_b, 1'b1, "B driver off when disconnected");
    @(posedge clk);
    dir_a <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(oe_n_a, 1'b1, "A driver off for input");
    @(posedge clk);
    dir_a <= 1'b1;
    for (c = 2; c < 5; c++) begin
      cfg(`TMR16_MODE_NORMAL, c[1:0] ^ 2'b01 ^ 2'b01 ^ ((c == 4) ? 2'b01 : 2'b00),
          `TMR16_COM_SET, 16'h0003, 16'h0000, `TMR16_SEL_DIV1);
      // This clear lands on the first tick, where B matches at zero
      wr(`TMR16_OFS_FLAGS, 8'h04);
      wait_flag(1, 20);
      chk(wave_a, (c == 3), "clear or set on match");
      chk(wave_b, 1'b1, "B set on match at zero");
      chk(match[1], 1'b1, "B flag set beats clear");
    end
    cfg(`TMR16_MODE_NORMAL, `TMR16_COM_OFF, `TMR16_COM_OFF, 16'h1000, 16'hFFF8,
        `TMR16_SEL_DIV1);
    #1;
    chk(ovf, 1'b0, "no overflow before MAX");
    wait_flag(0, 20);
    wr(`TMR16_OFS_CTRL_B, 8'h00);
  endtask

  task t_fast;
    int c;
    for (c = 2; c < 4; c++) begin
      cfg(`TMR16_MODE_FAST8, c[1:0], `TMR16_COM_OFF, 16'h0010, 16'h0000, `TMR16_SEL_DIV1);
      wait_flag(1, 40);
      chk(wave_a, (c == 3), "fast match action");
      chk(ovf, 1'b0, "fast overflow only at TOP");
      wait_flag(0, 300);
      repeat (3) @(posedge clk);
      #1;
      chk(wave_a, (c == 2), "fast bottom action");
      cfg(`TMR16_MODE_FAST8, c[1:0], `TMR16_COM_OFF, `TMR16_TOP_8, 16'h0000,
          `TMR16_SEL_DIV1);
      wait_flag(0, 300);
      chk(wave_a, (c == 2), "compare at TOP ignored");
    end
    wr(`TMR16_OFS_CTRL_B, 8'h00);
  endtask

  // Second pass runs phase-frequency mode with the same TOP held in capture
  task t_dual;
    int c;
    wr(`TMR16_OFS_CAP_LO, 8'hFF);
    wr(`TMR16_OFS_CAP_HI, 8'h00);
    for (c = 2; c < 4; c++) begin
      cfg((c == 2) ? `TMR16_MODE_PC8 : `TMR16_MODE_PFC_CAP, c[1:0], `TMR16_COM_OFF,
          16'h0020, 16'h0000, `TMR16_SEL_DIV1);
      wait_flag(1, 60);
      chk(wave_a, (c == 3), "dual match counting up");
      wr(`TMR16_OFS_FLAGS, 8'h0F);
      wait_flag(1, 600);
      chk(wave_a, (c == 2), "dual match counting down");
      chk(ovf, 1'b0, "no overflow at TOP in dual slope");
      wait_flag(0, 60);
    end
    wr(`TMR16_OFS_CTRL_B, 8'h00);
  endtask

  task t_ticks;
    int s, sh [5] = '{0, 3, 6, 8, 10};
    logic [15:0] v, w;
    for (s = 1; s < 6; s++) begin
      cfg(`TMR16_MODE_NORMAL, `TMR16_COM_OFF, `TMR16_COM_OFF, 16'h0000, 16'h0000, s[2:0]);
      repeat (2047) @(posedge clk);
      wr(`TMR16_OFS_CTRL_B, 8'h00);
      rd16(`TMR16_OFS_CNT_LO, v);
      comparisons++;
      if ($isunknown(v) || v > (16'd2048 >> sh[s-1]) + 1 ||
          v + 1 < (16'd2048 >> sh[s-1])) begin
        bad_count++;
        $display("[FAIL] %0t divider %0d count %0d", $time, s, v);
      end
    end
    repeat (20) @(posedge clk);
    rd16(`TMR16_OFS_CNT_LO, w);
    chk(w, v, "stopped counter holds");
    cfg(`TMR16_MODE_NORMAL, `TMR16_COM_OFF, `TMR16_COM_OFF, 16'h0000, 16'h0000,
        `TMR16_SEL_EXT_RISE);
    pulse(1'b0, 3);
    rd16(`TMR16_OFS_CNT_LO, v);
    chk(v, 16'h0003, "rising external edges");
    cfg(`TMR16_MODE_NORMAL, `TMR16_COM_OFF, `TMR16_COM_OFF, 16'h0000, 16'h0000,
        `TMR16_SEL_EXT_FALL);
    pulse(1'b0, 2);
    rd16(`TMR16_OFS_CNT_LO, v);
    chk(v, 16'h0002, "falling external edges");
    wr(`TMR16_OFS_CTRL_B, 8'h00);
  endtask

  // Capture is cut off while it defines TOP, live again in normal mode
  task t_capture;
    logic [7:0] d;
    cfg(`TMR16_MODE_FAST_CAP, `TMR16_COM_OFF, `TMR16_COM_OFF, 16'h0000, 16'h0000,
        `TMR16_SEL_STOP);
    wr(`TMR16_OFS_CTRL_B, 8'h58);
    pulse(1'b1, 1);
    rd(`TMR16_OFS_FLAGS, d); chk(d[3], 1'b0, "capture dropped");
    wr(`TMR16_OFS_CTRL_A, 8'h00);
    wr(`TMR16_OFS_CTRL_B, 8'h40);
    pulse(1'b1, 1);
    rd(`TMR16_OFS_FLAGS, d); chk(d[3], 1'b1, "capture in normal mode");
  endtask

  task wrap_up;
    $display("bad_count %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clk);
    bad_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    wrap_up();
  end

  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    #1;
    chk(oe_n_a, 1'b1, "driver off out of reset");
    t_regs();
    t_override();
    t_normal();
    t_fast();
    t_dual();
    t_ticks();
    t_capture();
    wrap_up();
  end
endmodule

`default_nettype wire
